/* File: core/pf_flag_bank.sv */
// Permanent-fail alert and fault flag bank with AXI4-Lite register access
//
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`default_nettype none

// Function
// - Alert bit mirrors raised enabled alert
// - Fault bit shows enabled check became fault
// - Bit 7 B: discharge short latch
// - B bits 4,3: imbalance active, rest
// - B bit 2: second-level protector
// - B bits 1,0: discharge, charge switch
// - Alert C bits 6,5: mux, ground
// - Alert C bits 4,3: reference, oscillator
// - Fault C uses same positions 6..3
// - Fault C bit 7: commanded fail
// - Fault C bits 2,1: instruction, data ROM
// - Fault C bit 0: one-time memory
// - Alert D bit 0: stack vs cells
// - Summary bit 12 ORs all faults
module pf_flag_bank
	import pf_flags_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Check results, alert levels (same clock domain)
	input wire logic discharge_short_latch_alert_i,
	input wire logic imbalance_active_alert_i,
	input wire logic imbalance_rest_alert_i,
	input wire logic second_level_protector_alert_i,
	input wire logic discharge_switch_alert_i,
	input wire logic charge_switch_alert_i,
	input wire logic mux_check_alert_i,
	input wire logic ground_measure_alert_i,
	input wire logic vref_alert_i,
	input wire logic low_freq_osc_alert_i,
	input wire logic stack_vs_cell_sum_alert_i,
	// Check results, fault trigger levels
	input wire logic discharge_short_latch_fail_i,
	input wire logic imbalance_active_fail_i,
	input wire logic imbalance_rest_fail_i,
	input wire logic second_level_protector_fail_i,
	input wire logic discharge_switch_fail_i,
	input wire logic charge_switch_fail_i,
	input wire logic commanded_fail_i,
	input wire logic mux_check_fail_i,
	input wire logic ground_measure_fail_i,
	input wire logic vref_fail_i,
	input wire logic low_freq_osc_fail_i,
	input wire logic instruction_rom_fail_i,
	input wire logic data_rom_fail_i,
	input wire logic one_time_memory_fail_i,
	// Per-check enables: 0 keeps the check out of the bank
	input wire logic [7:0] enable_b_i,
	input wire logic [7:0] enable_c_i,
	input wire logic [7:0] enable_d_i,
	// Device-level fault clear request, one-cycle pulse
	input wire logic fault_clear_i,
	// Summary and interrupt
	output logic permanent_fail_summary_o,
	output logic irq_o,
	// AXI4-Lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// ----------------------------------------------------------------
	// Raw check vectors packed into register layout
	// ----------------------------------------------------------------
	pf_flags_s alert_raw; // Alert inputs in bit positions
	pf_flags_s fail_raw; // Fault inputs in bit positions
	pf_flags_s alert_q; // Registered alert view
	pf_flags_s fault_q; // Sticky fault view
	pf_flags_s next_fault; // Fault next state
	logic [2:0] irq_stat; // Sticky interrupt status
	logic [2:0] irq_mask; // Interrupt enables
	logic sw_clear; // Software fault-clear pulse

	always_comb begin
		alert_raw = '0;
		alert_raw.b[BIT_DISCHARGE_SHORT_LATCH] = discharge_short_latch_alert_i;
		alert_raw.b[BIT_IMBALANCE_ACTIVE] = imbalance_active_alert_i;
		alert_raw.b[BIT_IMBALANCE_REST] = imbalance_rest_alert_i;
		alert_raw.b[BIT_SECOND_LEVEL] = second_level_protector_alert_i;
		alert_raw.b[BIT_DISCHARGE_SWITCH] = discharge_switch_alert_i;
		alert_raw.b[BIT_CHARGE_SWITCH] = charge_switch_alert_i;
		alert_raw.c[BIT_MUX] = mux_check_alert_i;
		alert_raw.c[BIT_GROUND] = ground_measure_alert_i;
		alert_raw.c[BIT_VREF] = vref_alert_i;
		alert_raw.c[BIT_OSC] = low_freq_osc_alert_i;
		alert_raw.d[BIT_STACK_SUM] = stack_vs_cell_sum_alert_i;
	end

	always_comb begin
		fail_raw = '0;
		fail_raw.b[BIT_DISCHARGE_SHORT_LATCH] = discharge_short_latch_fail_i;
		fail_raw.b[BIT_IMBALANCE_ACTIVE] = imbalance_active_fail_i;
		fail_raw.b[BIT_IMBALANCE_REST] = imbalance_rest_fail_i;
		fail_raw.b[BIT_SECOND_LEVEL] = second_level_protector_fail_i;
		fail_raw.b[BIT_DISCHARGE_SWITCH] = discharge_switch_fail_i;
		fail_raw.b[BIT_CHARGE_SWITCH] = charge_switch_fail_i;
		fail_raw.c[BIT_COMMANDED] = commanded_fail_i;
		fail_raw.c[BIT_MUX] = mux_check_fail_i;
		fail_raw.c[BIT_GROUND] = ground_measure_fail_i;
		fail_raw.c[BIT_VREF] = vref_fail_i;
		fail_raw.c[BIT_OSC] = low_freq_osc_fail_i;
		fail_raw.c[BIT_INSTR_ROM] = instruction_rom_fail_i;
		fail_raw.c[BIT_DATA_ROM] = data_rom_fail_i;
		fail_raw.c[BIT_OTP] = one_time_memory_fail_i;
		fail_raw.d = '0; // Fault D lives outside this bank
	end

	// ----------------------------------------------------------------
	// Alert flags: live view of enabled alerts, one cycle late
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			alert_q <= '0;
		end else begin
			alert_q.b <= alert_raw.b & enable_b_i & MASK_B;
			alert_q.c <= alert_raw.c & enable_c_i & MASK_ALERT_C;
			alert_q.d <= alert_raw.d & enable_d_i & MASK_D;
		end
	end

	// ----------------------------------------------------------------
	// Fault flags: sticky, a new trigger beats a clear
	// ----------------------------------------------------------------
	always_comb begin
		next_fault = fault_q;
		if (fault_clear_i || sw_clear) begin
			next_fault = '0;
		end
		next_fault.b = next_fault.b | (fail_raw.b & enable_b_i & MASK_B);
		next_fault.c = next_fault.c | (fail_raw.c & enable_c_i & MASK_FAULT_C);
		next_fault.d = '0;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			fault_q <= '0;
		end else begin
			fault_q <= next_fault;
		end
	end

	// Summary follows the fault registers
	assign permanent_fail_summary_o = |{fault_q.b, fault_q.c};

	// ----------------------------------------------------------------
	// Interrupt status: rising fault per register, write-one-to-clear
	// ----------------------------------------------------------------
	logic [2:0] irq_event; // New fault bits per register
	logic [2:0] irq_w1c; // Software clear bits
	logic wr_fire; // Write accepted this cycle
	logic [7:0] wr_addr; // Latched write address
	logic [31:0] wr_data; // Latched write data
	logic aw_held; // Address taken, waiting on data
	logic w_held; // Data taken, waiting on address

	assign irq_event[IRQ_FAULT_B] = |(next_fault.b & ~fault_q.b);
	assign irq_event[IRQ_FAULT_C] = |(next_fault.c & ~fault_q.c);
	assign irq_event[IRQ_FAULT_D] = 1'b0;
	assign irq_w1c = (wr_fire && wr_addr == ADDR_IRQ_STAT) ? wr_data[2:0] : 3'h0;
	assign sw_clear = wr_fire && wr_addr == ADDR_CLEAR && wr_data[0];

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			irq_stat <= '0;
		end else begin
			// Set wins over a simultaneous clear
			irq_stat <= (irq_stat & ~irq_w1c) | irq_event;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			irq_mask <= IRQ_MASK_RESET;
		end else if (wr_fire && wr_addr == ADDR_IRQ_MASK) begin
			irq_mask <= wr_data[2:0];
		end
	end

	assign irq_o = |(irq_stat & irq_mask);

	// ----------------------------------------------------------------
	// AXI4-Lite write channel: address and data in either order
	// ----------------------------------------------------------------
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign wr_fire = aw_held && w_held;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			wr_addr <= '0;
			wr_data <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				wr_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				// Byte lane 0 carries all writable bits
				wr_data <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0000_0000;
			end
			if (wr_fire) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				// Flag registers take no write; unmapped answers error
				case (wr_addr)
					ADDR_ALERT_B, ADDR_FAULT_B, ADDR_ALERT_C, ADDR_FAULT_C, ADDR_ALERT_D, ADDR_SUMMARY,
					ADDR_CLEAR, ADDR_IRQ_STAT, ADDR_IRQ_MASK: begin
						s_axi_bresp <= RESP_OKAY;
					end
					default: begin
						s_axi_bresp <= RESP_SLVERR;
					end
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------------------------------
	rd_state_e rd_state; // Read state
	logic [31:0] rd_mux; // Selected read word
	logic rd_ok; // Address is mapped

	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_ok = 1'b1;
		case (s_axi_araddr)
			ADDR_ALERT_B: rd_mux[7:0] = alert_q.b;
			ADDR_FAULT_B: rd_mux[7:0] = fault_q.b;
			ADDR_ALERT_C: rd_mux[7:0] = alert_q.c;
			ADDR_FAULT_C: rd_mux[7:0] = fault_q.c;
			ADDR_ALERT_D: rd_mux[7:0] = alert_q.d;
			ADDR_SUMMARY: rd_mux[BIT_SUMMARY] = permanent_fail_summary_o;
			ADDR_CLEAR: rd_mux = 32'h0000_0000;
			ADDR_IRQ_STAT: rd_mux[2:0] = irq_stat;
			ADDR_IRQ_MASK: rd_mux[2:0] = irq_mask;
			default: rd_ok = 1'b0;
		endcase
	end

	assign s_axi_arready = (rd_state == RD_IDLE);

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rd_state <= RD_IDLE;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			case (rd_state)
				RD_IDLE: begin
					if (s_axi_arvalid) begin
						s_axi_rdata <= rd_mux;
						s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
						s_axi_rvalid <= 1'b1;
						rd_state <= RD_RESP;
					end
				end
				RD_RESP: begin
					if (s_axi_rready) begin
						s_axi_rvalid <= 1'b0;
						rd_state <= RD_IDLE;
					end
				end
				default: begin
					rd_state <= RD_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_alert_follows: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		alert_q.b == ($past(alert_raw.b) & $past(enable_b_i) & MASK_B))
		else $error("alert B does not follow enabled checks");
	chk_fault_sets: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(charge_switch_fail_i && enable_b_i[BIT_CHARGE_SWITCH]) |=> fault_q.b[BIT_CHARGE_SWITCH])
		else $error("charge switch fault not set");
	chk_short_latch_bit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(discharge_short_latch_fail_i && enable_b_i[7]) |=> fault_q.b[7])
		else $error("short latch fault not at bit 7");
	chk_commanded_bit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(commanded_fail_i && enable_c_i[7]) |=> fault_q.c[7])
		else $error("commanded fault not at bit 7");
	chk_otp_bit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(one_time_memory_fail_i && enable_c_i[0]) |=> fault_q.c[0])
		else $error("one-time memory fault not at bit 0");
	chk_stack_alert: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(stack_vs_cell_sum_alert_i && enable_d_i[0]) |=> alert_q.d == 8'h01)
		else $error("stack alert not at bit 0");
	chk_summary_tracks: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		permanent_fail_summary_o == ((fault_q.b | fault_q.c) != 8'h00))
		else $error("summary disagrees with faults");
	chk_reserved_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(fault_q.b & ~MASK_B) == 8'h00 && (alert_q.c & ~MASK_ALERT_C) == 8'h00)
		else $error("reserved bit set");
	chk_fault_sticky: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(fault_q.c[BIT_MUX] && !fault_clear_i && !sw_clear) |=> fault_q.c[BIT_MUX])
		else $error("fault dropped without clear");
	chk_read_answer: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
		else $error("read not answered next cycle");
	cov_fault_raised: cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(permanent_fail_summary_o));
	cov_fault_cleared: cover property (@(posedge clk_i) disable iff (!rst_n_i) $fell(permanent_fail_summary_o));
	cov_irq: cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(irq_o));
	cov_write_resp: cover property (@(posedge clk_i) disable iff (!rst_n_i) s_axi_bvalid && s_axi_bready);

endmodule
`default_nettype wire

/* File: core/pf_flags_pkg.sv */
// Package: register map, field positions and carriers for the permanent-fail flag bank
`default_nettype none
package pf_flags_pkg;

	// ----------------------------------------------------------------
	// Register byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_ALERT_B = 8'h00;
	localparam logic [7:0] ADDR_FAULT_B = 8'h04;
	localparam logic [7:0] ADDR_ALERT_C = 8'h08;
	localparam logic [7:0] ADDR_FAULT_C = 8'h0C;
	localparam logic [7:0] ADDR_ALERT_D = 8'h10;
	localparam logic [7:0] ADDR_SUMMARY = 8'h14;
	localparam logic [7:0] ADDR_CLEAR = 8'h18;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h1C;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int BIT_DISCHARGE_SHORT_LATCH = 7;
	localparam int BIT_IMBALANCE_ACTIVE = 4;
	localparam int BIT_IMBALANCE_REST = 3;
	localparam int BIT_SECOND_LEVEL = 2;
	localparam int BIT_DISCHARGE_SWITCH = 1;
	localparam int BIT_CHARGE_SWITCH = 0;
	localparam int BIT_COMMANDED = 7;
	localparam int BIT_MUX = 6;
	localparam int BIT_GROUND = 5;
	localparam int BIT_VREF = 4;
	localparam int BIT_OSC = 3;
	localparam int BIT_INSTR_ROM = 2;
	localparam int BIT_DATA_ROM = 1;
	localparam int BIT_OTP = 0;
	localparam int BIT_STACK_SUM = 0;
	localparam int BIT_SUMMARY = 12;

	// Implemented-bit masks; every other bit reads zero
	localparam logic [7:0] MASK_B = 8'h9F;
	localparam logic [7:0] MASK_ALERT_C = 8'h78;
	localparam logic [7:0] MASK_FAULT_C = 8'hFF;
	localparam logic [7:0] MASK_D = 8'h01;

	// Interrupt status bits: one per fault register newly set
	localparam int IRQ_FAULT_B = 0;
	localparam int IRQ_FAULT_C = 1;
	localparam int IRQ_FAULT_D = 2;
	localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] b;
		logic [7:0] c;
		logic [7:0] d;
	} pf_flags_s;

	typedef enum logic [1:0] {
		RD_IDLE,
		RD_RESP
	} rd_state_e;

endpackage
`default_nettype wire

/* File: test/tb_top.sv */
// Self-checking bench for the permanent-fail flag bank
`default_nettype none
module tb_top
	import pf_flags_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	localparam int TIMEOUT = 20000; // Run needs a few hundred cycles
	logic clk_i, rst_n_i, fault_clear, summary, irq;
	logic [7:0] al_b, al_c, al_d, fl_b, fl_c, en_b, en_c, en_d; // Check levels in register layout
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [33:0] rd_q[$]; // Expected {rresp, rdata}, oldest first
	logic [1:0] wr_q[$]; // Expected bresp
	logic [33:0] exp_r;
	logic [63:0] rnd;
	logic [7:0] exp_fb, exp_fc;
	int mismatches, cmp_count, cycles;

	pf_flag_bank u_dut (
		.clk_i(clk_i), .rst_n_i(rst_n_i),
		.discharge_short_latch_alert_i(al_b[7]), .imbalance_active_alert_i(al_b[4]),
		.imbalance_rest_alert_i(al_b[3]), .second_level_protector_alert_i(al_b[2]),
		.discharge_switch_alert_i(al_b[1]), .charge_switch_alert_i(al_b[0]),
		.mux_check_alert_i(al_c[6]), .ground_measure_alert_i(al_c[5]), .vref_alert_i(al_c[4]),
		.low_freq_osc_alert_i(al_c[3]), .stack_vs_cell_sum_alert_i(al_d[0]),
		.discharge_short_latch_fail_i(fl_b[7]), .imbalance_active_fail_i(fl_b[4]),
		.imbalance_rest_fail_i(fl_b[3]), .second_level_protector_fail_i(fl_b[2]),
		.discharge_switch_fail_i(fl_b[1]), .charge_switch_fail_i(fl_b[0]),
		.commanded_fail_i(fl_c[7]), .mux_check_fail_i(fl_c[6]), .ground_measure_fail_i(fl_c[5]),
		.vref_fail_i(fl_c[4]), .low_freq_osc_fail_i(fl_c[3]), .instruction_rom_fail_i(fl_c[2]),
		.data_rom_fail_i(fl_c[1]), .one_time_memory_fail_i(fl_c[0]),
		.enable_b_i(en_b), .enable_c_i(en_c), .enable_d_i(en_d), .fault_clear_i(fault_clear),
		.permanent_fail_summary_o(summary), .irq_o(irq),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
	);

	// ------------------------------------------------------------
	// Clock, timeout and verdict
	// ------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	task automatic complete_run();
		if (mismatches == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", n, exp, seen);
		end
	endtask

	// A hang counts as a mismatch and ends the run
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == TIMEOUT) begin
			mismatches++;
			complete_run();
		end
	end

	// ------------------------------------------------------------
	// Response monitor: oldest note against each answer
	// ------------------------------------------------------------
	always @(posedge clk_i) begin
		if (s_axi_rvalid && s_axi_rready) begin
			if (rd_q.size() == 0) begin
				check("read_note", 32'h1, 32'h0);
			end else begin
				exp_r = rd_q.pop_front();
				check("rdata", s_axi_rdata, exp_r[31:0]);
				check("rresp", {30'h0, s_axi_rresp}, {30'h0, exp_r[33:32]});
			end
		end
		if (s_axi_bvalid && s_axi_bready) begin
			if (wr_q.size() == 0) begin
				check("write_note", 32'h1, 32'h0);
			end else begin
				check("bresp", {30'h0, s_axi_bresp}, {30'h0, wr_q.pop_front()});
			end
		end
	end

	// ------------------------------------------------------------
	// Bus tasks; each starts one edge on so no signal is set twice
	// ------------------------------------------------------------
	task automatic axi_read(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge clk_i);
		rd_q.push_back({r, d});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk_i); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk_i); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask

	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge clk_i);
		wr_q.push_back(r);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// Each channel is released at its own taking edge
		while (!(aw_ok && w_ok)) begin
			@(posedge clk_i);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge clk_i); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask

	task automatic pulse_fail(input logic [7:0] b, input logic [7:0] c);
		@(posedge clk_i);
		fl_b <= b;
		fl_c <= c;
		@(posedge clk_i);
		fl_b <= 8'h00;
		fl_c <= 8'h00;
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{rst_n_i, fault_clear, al_b, al_c, al_d, fl_b, fl_c, en_b, en_c, en_d} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		mismatches = 0;
		cmp_count = 0;
		cycles = 0;
		void'($urandom(32'ha5df));
		repeat (6) @(posedge clk_i);
		rst_n_i <= 1'b1;
		// Everything clear after reset; unmapped place refused
		for (int a = 0; a <= 8'h14; a += 4) axi_read(a[7:0], 32'h0, RESP_OKAY);
		axi_read(ADDR_IRQ_STAT, 32'h0, RESP_OKAY);
		axi_read(ADDR_IRQ_MASK, {29'h0, IRQ_MASK_RESET}, RESP_OKAY);
		axi_read(8'h30, 32'h0, RESP_SLVERR);
		axi_write(8'h30, 32'hFFFF_FFFF, RESP_SLVERR);
		// Random alerts and enables; reserved bits never show
		for (int k = 0; k < 16; k++) begin
			rnd = {$urandom, $urandom};
			@(posedge clk_i);
			{al_b, al_c, al_d, en_b, en_c, en_d} <= rnd[47:0];
			axi_read(ADDR_ALERT_B, {24'h0, rnd[47:40] & rnd[23:16] & MASK_B}, RESP_OKAY);
			axi_read(ADDR_ALERT_C, {24'h0, rnd[39:32] & rnd[15:8] & MASK_ALERT_C}, RESP_OKAY);
			axi_read(ADDR_ALERT_D, {24'h0, rnd[31:24] & rnd[7:0] & MASK_D}, RESP_OKAY);
		end
		// Writes to flag registers change nothing
		for (int a = 0; a <= 8'h10; a += 4) axi_write(a[7:0], 32'hFFFF_FFFF, RESP_OKAY);
		axi_read(ADDR_ALERT_B, {24'h0, rnd[47:40] & rnd[23:16] & MASK_B}, RESP_OKAY);
		axi_read(ADDR_FAULT_C, 32'h0, RESP_OKAY);
		// Disabled checks never become faults
		en_b <= 8'h00;
		en_c <= 8'h00;
		pulse_fail(8'hFF, 8'hFF);
		axi_read(ADDR_FAULT_B, 32'h0, RESP_OKAY);
		axi_read(ADDR_FAULT_C, 32'h0, RESP_OKAY);
		check("summary_off", {31'h0, summary}, 32'h0);
		en_b <= 8'hFF;
		en_c <= 8'hFF;
		// Walk one trigger pulse per bit; earlier flags must hold
		exp_fb = 8'h00;
		exp_fc = 8'h00;
		for (int i = 0; i < 8; i++) begin
			pulse_fail(8'h01 << i, 8'h00);
			exp_fb |= (8'h01 << i) & MASK_B;
			axi_read(ADDR_FAULT_B, {24'h0, exp_fb}, RESP_OKAY);
		end
		for (int i = 0; i < 8; i++) begin
			pulse_fail(8'h00, 8'h01 << i);
			exp_fc |= (8'h01 << i) & MASK_FAULT_C;
			axi_read(ADDR_FAULT_C, {24'h0, exp_fc}, RESP_OKAY);
		end
		axi_read(ADDR_SUMMARY, 32'h0000_1000, RESP_OKAY);
		check("summary_on", {31'h0, summary}, 32'h1);
		// Interrupt: masked, unmasked, cleared bit by bit
		check("irq_masked", {31'h0, irq}, 32'h0);
		axi_read(ADDR_IRQ_STAT, 32'h0000_0003, RESP_OKAY);
		axi_write(ADDR_IRQ_MASK, 32'h0000_0003, RESP_OKAY);
		check("irq_unmasked", {31'h0, irq}, 32'h1);
		axi_write(ADDR_IRQ_STAT, 32'h0000_0001, RESP_OKAY);
		check("irq_one_left", {31'h0, irq}, 32'h1);
		axi_read(ADDR_IRQ_STAT, 32'h0000_0002, RESP_OKAY);
		axi_write(ADDR_IRQ_STAT, 32'h0000_0002, RESP_OKAY);
		check("irq_cleared", {31'h0, irq}, 32'h0);
		axi_read(ADDR_FAULT_B, {24'h0, exp_fb}, RESP_OKAY);
		// Clear by register, then by the device pin
		axi_write(ADDR_CLEAR, 32'h0000_0001, RESP_OKAY);
		axi_read(ADDR_FAULT_B, 32'h0, RESP_OKAY);
		axi_read(ADDR_SUMMARY, 32'h0, RESP_OKAY);
		pulse_fail(8'h80, 8'h80);
		axi_read(ADDR_FAULT_B, 32'h0000_0080, RESP_OKAY);
		check("irq_new_fault", {31'h0, irq}, 32'h1);
		@(posedge clk_i);
		fault_clear <= 1'b1;
		@(posedge clk_i);
		fault_clear <= 1'b0;
		axi_read(ADDR_FAULT_C, 32'h0, RESP_OKAY);
		// Lane 0 strobe off: the write lands as zero
		s_axi_wstrb <= 4'h0;
		axi_write(ADDR_IRQ_MASK, 32'h0000_0003, RESP_OKAY);
		axi_read(ADDR_IRQ_MASK, 32'h0, RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		repeat (3) @(posedge clk_i);
		check("notes_left", rd_q.size() + wr_q.size(), 32'h0);
		complete_run();
	end

endmodule
`default_nettype wire
